/* hdl/hib_pkg.sv */
// Constants, register map and types of the hibernation power controller
package hib_pkg;
    // Register byte offsets
    localparam logic [8:0] OFF_CTRL   = 9'h000;
    localparam logic [8:0] OFF_COUNT  = 9'h004;
    localparam logic [8:0] OFF_LOAD   = 9'h008;
    localparam logic [8:0] OFF_MATCH0 = 9'h00c;
    localparam logic [8:0] OFF_MATCH1 = 9'h010;
    localparam logic [8:0] OFF_TRIM   = 9'h014;
    localparam logic [8:0] OFF_MASK   = 9'h018;
    localparam logic [8:0] OFF_RAW    = 9'h01c;
    localparam logic [8:0] OFF_MASKED = 9'h020;
    localparam int         MEM_BIT    = 8;       // Address bit that selects retained memory
    localparam int         MEM_DEPTH  = 64;
    localparam int         MEM_AW     = 6;
    // Control register fields
    localparam int CTL_W       = 8;
    localparam int CTL_SLEEP   = 0;
    localparam int CTL_ALARMWK = 1;
    localparam int CTL_SRCSEL  = 2;
    localparam int CTL_PINWK   = 3;
    localparam int CTL_LBEN    = 4;
    localparam int CTL_VETO    = 5;
    localparam int CTL_SLOWEN  = 6;
    localparam int CTL_RTCEN   = 7;
    localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;
    // Event bits, shared by raw status and mask
    localparam int EV_W      = 4;
    localparam int EV_MATCH0 = 0;
    localparam int EV_MATCH1 = 1;
    localparam int EV_LOWBAT = 2;
    localparam int EV_WAKE   = 3;
    localparam logic [EV_W-1:0] EV_RESET = 4'h0;
    // Clock dividers
    localparam int               XTAL_DIV_W  = 7;
    localparam logic [6:0]       XTAL_LAST   = 7'h7f;   // Divide by 128
    localparam int               TRIM_W      = 16;
    localparam logic [15:0]      TRIM_NOM    = 16'h7fff;
    localparam int               SEC_W       = 6;       // Trim used once per 64 seconds
    localparam int               SYNC_STAGES = 2;
    // Power state
    typedef enum {ST_RUN, ST_SLEEP} pwr_state_t;
endpackage

/* hdl/hibernation_power_control.sv */
// Hibernation power controller: regulator enable, wake sources, RTC, retained memory
// Functional notes
// R1: Drive regulator power-down enable output
// R2: Wake on pin or counter match
// R3: Detect low battery, optionally refuse sleep
// R4: Software spaces writes and write-then-read
// R5: Back-to-back reads need no spacing
// R6: External slow clock always supplied
// R7: Slow clock gated by enable bit
// R8: Select crystal divided by 128 or oscillator
// R9: Software waits crystal settling after enable
// R10: 32-bit counter and two match registers
// R11: 64 words of retained storage
// R12: Maskable match, wake, low battery interrupts
// R13: Trim divide once per 64 seconds
// R14: Sleep request bit starts hibernation
// R15: Separate pin and match wake enables
// R16: Low battery veto blocks sleep entry
// R17: Writes pass synchronizer before taking effect
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/10ps
module hibernation_power_control
    import hib_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Register port
    input  wire logic [8:0]  addr,
    input  wire logic [31:0] wrData,
    input  wire logic        wrStrobe,
    input  wire logic        rdStrobe,
    output logic      [31:0] rdData,
    // Pins and analog status
    input  wire logic        wakePin_n,
    input  wire logic        lowBattery,
    input  wire logic        crystalIn,
    input  wire logic        oscIn,
    output logic             powerDownEnable_n,
    output logic             irq
);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // Register state
    logic [CTL_W-1:0]  ctl;            // Control bits
    logic [31:0]       rtc;            // Seconds counter
    logic [31:0]       match0;         // First match value
    logic [31:0]       match1;         // Second match value
    logic [TRIM_W-1:0] trim;           // Predivider trim
    logic [EV_W-1:0]   mask;           // Interrupt mask
    logic [EV_W-1:0]   raw;            // Sticky event status
    logic [31:0]       mem [MEM_DEPTH];  // Retained words
    // Staged write
    logic [SYNC_STAGES-1:0] wrPend;    // Write strobe synchronizer
    logic [8:0]        stAddr;         // Held write address
    logic [31:0]       stData;         // Held write data
    logic              apply;          // Staged write takes effect
    // Clock chain
    logic              xtalPrev;       // Last crystal sample
    logic              oscPrev;        // Last oscillator sample
    logic [XTAL_DIV_W-1:0] prescale;   // Crystal divider
    logic [TRIM_W-1:0] preCount;       // Predivider countdown
    logic [SEC_W-1:0]  secIdx;         // Second within trim period
    logic              refTick;        // One 32.768 kHz reference edge
    logic              secTick;        // One second elapsed
    // Power state and pins
    pwr_state_t        state;
    logic              wakePrev;       // Last wake pin sample
    logic              lbPrev;         // Last low battery sample
    logic [31:0]       readMux;        // Read value of the current address

    // Next values
    logic [SYNC_STAGES-1:0] next_wrPend;
    logic [8:0]        next_stAddr;
    logic [31:0]       next_stData;
    logic [CTL_W-1:0]  next_ctl;
    logic [31:0]       next_rtc, next_match0, next_match1, next_rdData;
    logic [TRIM_W-1:0] next_trim, next_preCount;
    logic [EV_W-1:0]   next_mask, next_raw, evSet;
    logic [XTAL_DIV_W-1:0] next_prescale;
    logic [SEC_W-1:0]  next_secIdx;
    pwr_state_t        next_state;
    logic              next_powerDownEnable_n;  // Registered regulator enable
    logic              next_irq;                // Registered interrupt level
    logic              xtalRise, oscRise, rtcStep, wakeSrc, veto, pinWake, alarmWake, matchHit0, matchHit1;

    // Staged write path: data held, strobe delayed through two flops [R17]
    always_comb begin
        next_wrPend = {wrPend[SYNC_STAGES-2:0], wrStrobe};  // [R17]
        next_stAddr = wrStrobe ? addr : stAddr;
        next_stData = wrStrobe ? wrData : stData;
    end
    assign apply = wrPend[SYNC_STAGES-1];

    always_ff @(posedge mclk) begin
        if (rst) begin
            wrPend <= '0;
            stAddr <= '0;
            stData <= '0;
        end else begin
            wrPend <= next_wrPend;
            stAddr <= next_stAddr;
            stData <= next_stData;
        end
    end

    // Reference clock: crystal divided by 128 or oscillator, only while enabled [R7] [R8]
    always_comb begin
        xtalRise      = crystalIn & ~xtalPrev;
        oscRise       = oscIn & ~oscPrev;
        next_prescale = prescale;
        if (ctl[CTL_SLOWEN] && !ctl[CTL_SRCSEL] && xtalRise) begin
            next_prescale = prescale + 7'h01;            // Wraps at 128 [R8]
        end
        if (!ctl[CTL_SLOWEN]) begin
            refTick = 1'b0;                              // Gated off [R7]
        end else if (ctl[CTL_SRCSEL]) begin
            refTick = oscRise;                           // Oscillator passes straight [R8]
        end else begin
            refTick = xtalRise && (prescale == XTAL_LAST);  // [R8]
        end
    end

    // Predivider: trim value for one second in 64, nominal otherwise [R13]
    always_comb begin
        next_preCount = preCount;
        next_secIdx   = secIdx;
        secTick       = 1'b0;
        if (refTick) begin
            if (preCount == '0) begin
                secTick       = 1'b1;
                next_secIdx   = secIdx + 6'h01;
                next_preCount = (secIdx == '0) ? trim : TRIM_NOM;  // [R13]
            end else begin
                next_preCount = preCount - 16'h0001;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            xtalPrev <= 1'b0;
            oscPrev  <= 1'b0;
            prescale <= '0;
            preCount <= TRIM_NOM;
            secIdx   <= '0;
        end else begin
            xtalPrev <= crystalIn;
            oscPrev  <= oscIn;
            prescale <= next_prescale;
            preCount <= next_preCount;
            secIdx   <= next_secIdx;
        end
    end

    // Power sequencing; battery is only judged while running
    always_comb begin
        wakeSrc    = ctl[CTL_PINWK] | ctl[CTL_ALARMWK];                // [R15]
        veto       = ctl[CTL_LBEN] & ctl[CTL_VETO] & lowBattery;        // [R3] [R16]
        rtcStep    = secTick & ctl[CTL_RTCEN];
        matchHit0  = rtcStep && ((rtc + 32'h1) == match0);             // [R10]
        matchHit1  = rtcStep && ((rtc + 32'h1) == match1);             // [R10]
        pinWake    = ctl[CTL_PINWK] & ~wakePin_n;                      // [R15]
        alarmWake  = ctl[CTL_ALARMWK] & (matchHit0 | matchHit1);       // [R15]
        next_state = state;
        case (state)
            ST_RUN: begin
                // Request without wake source or under veto is dropped [R14] [R16]
                if (ctl[CTL_SLEEP] && wakeSrc && !veto) begin
                    next_state = ST_SLEEP;                             // [R14]
                end
            end
            ST_SLEEP: begin
                if (pinWake || alarmWake) begin
                    next_state = ST_RUN;                               // [R2]
                end
            end
            default: next_state = ST_RUN;
        endcase
        next_powerDownEnable_n = (next_state != ST_SLEEP);            // Low turns regulator off [R1]
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state             <= ST_RUN;
            powerDownEnable_n <= 1'b1;
            wakePrev          <= 1'b1;
            lbPrev            <= 1'b0;
        end else begin
            state             <= next_state;
            powerDownEnable_n <= next_powerDownEnable_n;               // [R1]
            wakePrev          <= wakePin_n;
            lbPrev            <= lowBattery;
        end
    end

    // Register file: applied writes, counter, events; hardware set beats clear
    always_comb begin
        next_ctl    = ctl;
        next_rtc    = rtcStep ? rtc + 32'h1 : rtc;                     // [R10]
        next_match0 = match0;
        next_match1 = match1;
        next_trim   = trim;
        next_mask   = mask;
        next_raw    = raw;
        evSet       = '0;
        evSet[EV_MATCH0] = matchHit0;                                  // [R12]
        evSet[EV_MATCH1] = matchHit1;                                  // [R12]
        evSet[EV_WAKE]   = wakePrev & ~wakePin_n;                      // Falling pin edge [R12]
        evSet[EV_LOWBAT] = ctl[CTL_LBEN] & lowBattery & ~lbPrev & (state == ST_RUN);  // [R3] [R12]
        if (apply) begin
            case (stAddr)
                OFF_CTRL:   next_ctl    = stData[CTL_W-1:0];
                OFF_LOAD:   next_rtc    = stData;
                OFF_MATCH0: next_match0 = stData;
                OFF_MATCH1: next_match1 = stData;
                OFF_TRIM:   next_trim   = stData[TRIM_W-1:0];
                OFF_MASK:   next_mask   = stData[EV_W-1:0];
                OFF_RAW:    next_raw    = raw & ~stData[EV_W-1:0];     // Write one to clear
                default:    next_raw    = next_raw;
            endcase
        end
        // Request is consumed once acted on or refused
        if (state == ST_RUN && ctl[CTL_SLEEP]) begin
            next_ctl[CTL_SLEEP] = 1'b0;                                // [R14]
        end
        next_raw = next_raw | evSet;
        next_irq = |(next_raw & next_mask);                            // [R12]
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctl    <= CTL_RESET;
            rtc    <= '0;
            match0 <= '1;
            match1 <= '1;
            trim   <= TRIM_NOM;
            mask   <= EV_RESET;
            raw    <= EV_RESET;
            irq    <= 1'b0;
        end else begin
            ctl    <= next_ctl;
            rtc    <= next_rtc;
            match0 <= next_match0;
            match1 <= next_match1;
            trim   <= next_trim;
            mask   <= next_mask;
            raw    <= next_raw;
            irq    <= next_irq;                                        // [R12]
        end
    end

    // Retained memory: no reset, contents survive hibernation [R11]
    always_ff @(posedge mclk) begin
        if (apply && stAddr[MEM_BIT]) begin
            mem[stAddr[MEM_AW+1:2]] <= stData;                         // [R11]
        end
    end

    // Read decode; reads are direct so they may follow each other freely [R5]
    always_comb begin
        readMux = '0;
        if (addr[MEM_BIT]) begin
            readMux = mem[addr[MEM_AW+1:2]];
        end else begin
            case (addr)
                OFF_CTRL:   readMux = {24'h000000, ctl};
                OFF_COUNT:  readMux = rtc;
                OFF_MATCH0: readMux = match0;
                OFF_MATCH1: readMux = match1;
                OFF_TRIM:   readMux = {16'h0000, trim};
                OFF_MASK:   readMux = {28'h0000000, mask};
                OFF_RAW:    readMux = {28'h0000000, raw};
                OFF_MASKED: readMux = {28'h0000000, raw & mask};
                default:    readMux = '0;                              // Unmapped reads zero
            endcase
        end
        next_rdData = rdStrobe ? readMux : '0;                         // [R5]
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdData <= '0;
        end else begin
            rdData <= next_rdData;
        end
    end

    // Checks
    sequence sWrCtl;
        wrStrobe && addr == OFF_CTRL ##1 !wrStrobe [*2];
    endsequence
    sequence sBackReads;
        rdStrobe ##1 rdStrobe;
    endsequence

    a_read_pair: assert property (sBackReads |=> rdData == $past(readMux))  // [R5]
        else $error("second read of a pair returned wrong data");
    a_ctl_sync: assert property (sWrCtl |=> ctl[CTL_W-1:1] == $past(wrData[CTL_W-1:1], 3))  // [R17]
        else $error("control write not applied after synchronizer");
    a_no_early: assert property (wrStrobe && addr == OFF_TRIM |=> trim == $past(trim))  // [R17]
        else $error("trim write took effect too early");
    a_enter_sleep: assert property (state == ST_RUN && ctl[CTL_SLEEP] && wakeSrc && !veto
        |=> !powerDownEnable_n && !ctl[CTL_SLEEP])  // [R14]
        else $error("sleep request did not switch regulator off");
    a_veto_hold: assert property (state == ST_RUN && veto |=> powerDownEnable_n)  // [R16]
        else $error("low battery veto did not block sleep");
    a_pin_wake: assert property (state == ST_SLEEP && pinWake |=> powerDownEnable_n)  // [R2]
        else $error("wake pin did not restore power");
    a_alarm_wake: assert property (state == ST_SLEEP && alarmWake |=> powerDownEnable_n)  // [R2]
        else $error("counter match did not restore power");
    a_clock_gate: assert property (!ctl[CTL_SLOWEN] |-> !refTick && !secTick)  // [R7]
        else $error("slow clock ran while disabled");
    a_trim_load: assert property (refTick && preCount == '0 && secIdx == '0 |=> preCount == $past(trim))  // [R13]
        else $error("trim not used for first second of period");
    a_irq_level: assert property ((raw & mask) != '0 |-> irq)  // [R12]
        else $error("interrupt low with unmasked event pending");
    a_raw_sticky: assert property (!apply |=> (raw & $past(raw)) == $past(raw))  // [R12]
        else $error("status bit lost without clear");

endmodule // hibernation_power_control

/* testbench/power_partner_model.sv */
// Model of the regulator, wake pin and slow clock sources around the controller
`timescale 1ns/10ps
module power_partner_model (
    // Clock
    input  wire logic mclk,
    // From the controller
    input  wire logic powerDownEnable_n,
    // Bench command
    input  wire logic pressWake,
    // To the controller
    output logic      wakePin_n,
    output logic      oscIn,
    output logic      crystalIn,
    // Regulator state
    output logic      railUp
);
    // Both sources run from time zero, even when the counter is unused
    // One process owns each output, so start values and toggling share a driver
    // Fast oscillator keeps one counter second near 65k cycles
    initial begin
        oscIn     = 1'b0;
        crystalIn = 1'b0;
        railUp    = 1'b1;
        forever begin
            @(posedge mclk);
            oscIn     <= ~oscIn;
            crystalIn <= ~crystalIn;
            railUp    <= powerDownEnable_n;   // Regulator follows its enable one cycle late
        end
    end
    // Weak pull-up holds the pin high when released
    assign wakePin_n = pressWake ? 1'b0 : 1'b1;
endmodule // power_partner_model

/* testbench/hibernation_power_control_tb.sv */
// Self-checking bench of the hibernation power controller
`timescale 1ns/10ps
`define CHECK(nm, exp, got) begin cmpCount++; if ((got) !== (exp)) begin mismatches++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module hibernation_power_control_tb
    import hib_pkg::*;
;
    // Bus and pins
    logic        mclk       = 1'b0;
    logic        rst        = 1'b1;
    logic [8:0]  addr       = 9'h000;
    logic [31:0] wrData     = 32'h0;
    logic        wrStrobe   = 1'b0;
    logic        rdStrobe   = 1'b0;
    logic        lowBattery = 1'b0;
    logic        pressWake  = 1'b0;
    logic [31:0] rdData;
    logic        wakePin_n;
    logic        crystalIn;
    logic        oscIn;
    logic        powerDownEnable_n;
    logic        irq;
    logic        railUp;
    // Bookkeeping
    int          mismatches = 0;
    int          cmpCount   = 0;
    logic [31:0] expQ[$];
    string       nameQ[$];
    logic [31:0] expVal;
    string       expName;
    logic        rdPend     = 1'b0;

    always #5 mclk = ~mclk;

    hibernation_power_control hibernation_power_control_inst (
        .mclk(mclk), .rst(rst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
        .rdStrobe(rdStrobe), .rdData(rdData), .wakePin_n(wakePin_n), .lowBattery(lowBattery),
        .crystalIn(crystalIn), .oscIn(oscIn), .powerDownEnable_n(powerDownEnable_n), .irq(irq));

    power_partner_model power_partner_model_inst (
        .mclk(mclk), .powerDownEnable_n(powerDownEnable_n), .pressWake(pressWake),
        .wakePin_n(wakePin_n), .oscIn(oscIn), .crystalIn(crystalIn), .railUp(railUp));

    // Read data stand only in the cycle after the strobe, so check them there
    always @(posedge mclk) begin
        if (rdPend) begin
            expVal = expQ.pop_front();
            expName = nameQ.pop_front();
            `CHECK(expName, expVal, rdData)
        end
        rdPend = rdStrobe;
    end

    // One write, then three idle cycles so the slow side sees it
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        rdStrobe <= 1'b0;
        @(posedge mclk);
        wrStrobe <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    // One read; reads may follow each other with no gap
    task automatic rd(input logic [8:0] a, input logic [31:0] e, input string nm);
        addr <= a;
        rdStrobe <= 1'b1;
        expQ.push_back(e);
        nameQ.push_back(nm);
        @(posedge mclk);
    endtask

    // Ends a burst of reads and lets the last one be checked
    task automatic rd_end();
        rdStrobe <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    // Bounded wait for the regulator enable to reach a level
    task automatic wait_pd(input logic lvl, input int lim, input string nm);
        int n;
        n = 0;
        while (powerDownEnable_n !== lvl && n < lim) begin
            @(posedge mclk);
            n++;
        end
        `CHECK(nm, lvl, powerDownEnable_n)
    endtask

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", cmpCount, mismatches);
        if (mismatches == 0 && cmpCount > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog: the alarm second alone needs about 66k cycles
    initial begin
        #1000000;
        mismatches++;
        $display("[FAIL] watchdog expected finish seen timeout");
        stop_test();
    end

    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        // Reset values and an unmapped place
        rd(OFF_CTRL, 32'h0, "ctrl");
        rd(OFF_TRIM, 32'h7fff, "trim");
        rd(OFF_MATCH0, 32'hffffffff, "match0");
        rd(OFF_MATCH1, 32'hffffffff, "match1");
        rd(OFF_MASK, 32'h0, "mask");
        rd(OFF_RAW, 32'h0, "raw");
        rd(9'h024, 32'h0, "unmapped");
        rd_end();
        `CHECK("powerOnReset", 1'b1, powerDownEnable_n)
        // Trim write lands only after the synchronizer, then reads back
        wr(OFF_TRIM, 32'h00007ff0);
        rd(OFF_TRIM, 32'h00007ff0, "trimWrite");
        // Retained words at both ends, read back to back
        wr(9'h100, 32'ha5a51234);
        wr(9'h1fc, 32'h5a5a8765);
        rd(9'h100, 32'ha5a51234, "mem0");
        rd(9'h1fc, 32'h5a5a8765, "mem63");
        rd(OFF_LOAD, 32'h0, "loadRead");
        rd_end();
        // Sleep request with no wake source is dropped
        wr(OFF_CTRL, 32'h01);
        repeat (4) @(posedge mclk);
        `CHECK("noWakeSource", 1'b1, powerDownEnable_n)
        rd(OFF_CTRL, 32'h0, "sleepCleared");
        rd_end();
        // Low battery event, interrupt, and veto of sleep
        wr(OFF_CTRL, 32'h38);
        lowBattery <= 1'b1;
        repeat (4) @(posedge mclk);
        wr(OFF_MASK, 32'h4);
        rd(OFF_RAW, 32'h4, "rawLowBat");
        rd_end();
        `CHECK("irqLowBat", 1'b1, irq)
        wr(OFF_CTRL, 32'h39);
        repeat (4) @(posedge mclk);
        `CHECK("vetoed", 1'b1, powerDownEnable_n)
        wr(OFF_RAW, 32'h4);
        repeat (2) @(posedge mclk);
        `CHECK("irqCleared", 1'b0, irq)
        lowBattery <= 1'b0;
        // Sleep, then wake from the pin
        wr(OFF_CTRL, 32'h09);
        wait_pd(1'b0, 8, "pinSleep");
        repeat (2) @(posedge mclk);
        `CHECK("railOff", 1'b0, railUp)
        pressWake <= 1'b1;
        @(posedge mclk);
        wait_pd(1'b1, 8, "pinWake");
        pressWake <= 1'b0;
        rd(OFF_RAW, 32'h8, "rawWake");
        rd_end();
        wr(OFF_RAW, 32'h8);
        // Oscillator selected, so no settle wait; sleep until the counter match
        wr(OFF_CTRL, 32'hc6);
        wr(OFF_LOAD, 32'h0);
        wr(OFF_MATCH0, 32'h1);
        wr(OFF_MATCH1, 32'h1);
        wr(OFF_MASK, 32'h1);
        wr(OFF_CTRL, 32'hc7);
        wait_pd(1'b0, 8, "alarmSleep");
        wait_pd(1'b1, 70000, "alarmWake");
        rd(OFF_COUNT, 32'h1, "count");
        rd(OFF_RAW, 32'h3, "rawMatch");
        rd(OFF_MASKED, 32'h1, "maskedMatch");
        rd_end();
        `CHECK("irqMatch", 1'b1, irq)
        stop_test();
    end
endmodule // hibernation_power_control_tb
